// ---- rtl/fsa_pkg.sv ----
package fsa_pkg;
  localparam int VAL_W       = 16;
  localparam int CH_N        = 2;
  localparam int IRQ_N       = 4;
  localparam int CLK_MHZ     = 100;
  localparam int MSG_TIME_MS = 500;
  localparam int MSG_CYCLES  = MSG_TIME_MS * CLK_MHZ * 1000;
  localparam logic [5:0] OFF_CTRL    = 6'h00;
  localparam logic [5:0] OFF_SP1     = 6'h04;
  localparam logic [5:0] OFF_SP2     = 6'h08;
  localparam logic [5:0] OFF_TRIP    = 6'h0C;
  localparam logic [5:0] OFF_LOCK    = 6'h10;
  localparam logic [5:0] OFF_STAT    = 6'h14;
  localparam logic [5:0] OFF_IRQ_ST  = 6'h18;
  localparam logic [5:0] OFF_IRQ_CLR = 6'h1C;
  localparam logic [5:0] OFF_IRQ_EN  = 6'h20;
  localparam logic [5:0] OFF_GAS     = 6'h24;
  localparam int CTRL_GAS    = 0;
  localparam int CTRL_EXT    = 1;
  localparam int IRQ_CLR     = 2;
  localparam int IRQ_REJ     = 3;
  localparam int STAT_MENU   = 8;
  localparam logic [1:0]  CTRL_RST = 2'h0;
  localparam logic [1:0]  TRIP_RST = 2'h3;
  localparam logic [15:0] LOCK_RST = 16'h0000;
  localparam logic [31:0] SP_RST   = 32'h0000_0000;
  localparam logic [3:0]  DIG_MAX  = 4'h9;

  typedef enum logic [4:0] {
    MS_RUN, MS_CODE, MS_RCODE, MS_SAVE, MS_BLANK, MS_VER,
    MS_FLUID, MS_PRES, MS_TEMP, MS_PULSE, MS_DAMP,
    MS_SP1T, MS_SP1H, MS_SP1D, MS_SP2T, MS_SP2H, MS_SP2D,
    MS_CLRGT, MS_PLOCK, MS_RLOCK
  } fsa_menu_t;

  typedef struct packed {
    logic menu;
    logic enter;
    logic up;
    logic right;
    logic hwrst;
  } fsa_btn_t;

  typedef struct packed {
    logic [VAL_W-1:0] hys;
    logic [VAL_W-1:0] thr;
  } fsa_setpt_t;

  // four bcd digits to binary, so limits compare in display units
  function automatic logic [16:0] fsa_bcd2bin(input logic [15:0] b);
    return 17'(b[15:12]) * 17'h3E8 + 17'(b[11:8]) * 17'h64
         + 17'(b[7:4]) * 17'hA + 17'(b[3:0]);
  endfunction : fsa_bcd2bin
endpackage : fsa_pkg

// ---- rtl/fsa_cmp.sv ----
`timescale 1ns/1ps
module fsa_cmp (
  input  wire logic               core_clk_in,
  input  wire logic               rst_b_in,
  input  wire logic               flow_valid_in,
  input  wire logic [15:0]        flow_in,
  input  wire fsa_pkg::fsa_setpt_t setpt_in,
  input  wire logic               trip_high_in,
  output logic                    conduct_out,
  output logic                    change_out
);
  import fsa_pkg::*;

  logic [16:0] thr;
  logic [16:0] hys;
  logic [16:0] flow;
  logic        conduct_reg;
  logic        conduct_next;
  logic        change_reg;

  assign thr  = fsa_bcd2bin(setpt_in.thr);
  assign hys  = fsa_bcd2bin(setpt_in.hys);
  assign flow = {1'b0, flow_in};

  always_comb
  begin
    conduct_next = conduct_reg;
    if (flow_valid_in)
    begin
      if (trip_high_in)
      begin
        if (flow >= thr)
          conduct_next = 1'b0;
        else if (flow + hys < thr)
          conduct_next = 1'b1;
      end
      else
      begin
        if (flow <= thr)
          conduct_next = 1'b1;
        else if (flow > thr + hys)
          conduct_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      conduct_reg <= 1'b0;
      change_reg  <= 1'b0;
    end
    else
    begin
      conduct_reg <= conduct_next;
      change_reg  <= conduct_next != conduct_reg;
    end
  end

  assign conduct_out = conduct_reg;
  assign change_out  = change_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  high_trip_a: assert property (flow_valid_in && trip_high_in && flow >= thr
    |=> !conduct_reg) else $error("high trip did not release output");
  low_trip_a: assert property (flow_valid_in && !trip_high_in && flow <= thr
    |=> conduct_reg) else $error("low trip did not pull output");
  band_hold_a: assert property (flow_valid_in && (trip_high_in
    ? (flow < thr && flow + hys >= thr) : (flow > thr && flow <= thr + hys))
    |=> $stable(conduct_reg)) else $error("output moved inside band");
  idle_hold_a: assert property (!flow_valid_in |=> $stable(conduct_reg))
    else $error("output moved without a rate result");
  trip_cov_c: cover property (conduct_reg ##1 !conduct_reg);
endmodule : fsa_cmp

// ---- rtl/fsa_top.sv ----
`timescale 1ns/1ps
module fsa_top #(
  parameter int          MSG_LEN    = fsa_pkg::MSG_CYCLES,
  parameter logic [15:0] FW_VERSION = 16'h0100  // arbitrary value
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_b_in,
  input  wire logic [5:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  input  wire fsa_pkg::fsa_btn_t   btn_in,
  input  wire logic                flow_valid_in,
  input  wire logic [15:0]         flow_rate_in,
  output logic      [1:0]          setpoint_oe_out,
  output logic      [1:0]          setpoint_dat_out,
  output logic                     total_clear_out,
  output fsa_pkg::fsa_menu_t       menu_state_out,
  output logic      [15:0]         edit_value_out,
  output logic      [1:0]          flash_digit_out,
  output logic                     irq_out
);
  import fsa_pkg::*;

  fsa_btn_t        s1_reg;
  fsa_btn_t        s2_reg;
  fsa_btn_t        s3_reg;
  fsa_btn_t        lvl_reg;
  fsa_btn_t        press;
  logic            menu_p;
  logic            enter_p;
  logic            combo;
  logic            ack_reg;
  logic [31:0]     rdata_reg;
  logic [31:0]     rmux;
  logic [31:0]     wval;
  logic            wr;
  logic [1:0]      ctrl_reg;
  logic [1:0]      trip_reg;
  fsa_setpt_t      sp_reg [CH_N];
  logic [15:0]     plock_reg;
  logic [15:0]     rlock_reg;
  logic [15:0]     pres_reg;
  logic [15:0]     temp_reg;
  fsa_menu_t       state_reg;
  fsa_menu_t       state_next;
  logic            ret_reg;
  logic [15:0]     edit_reg;
  logic [15:0]     load_val;
  logic [1:0]      dig_reg;
  logic [3:0]      nib;
  logic [31:0]     cnt_reg;
  logic            cnt_done;
  logic            gated;
  logic            match;
  logic            prog;
  logic            toggle_st;
  logic            num_st;
  logic            clr_reg;
  logic            clr_ev;
  logic            rej_ev;
  logic [CH_N-1:0] conduct;
  logic [CH_N-1:0] change;
  logic [IRQ_N-1:0] irq_st_reg;
  logic [IRQ_N-1:0] irq_en_reg;
  logic [IRQ_N-1:0] irq_clr;
  logic            irq_reg;

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i+:8] = n[8*i+:8];
    return r;
  endfunction : be_merge

  // panel pins are asynchronous: three stages, level moves when stages two and three agree
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end
    else
    begin
      s1_reg  <= btn_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= fsa_btn_t'((~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg));
    end
  end

  assign press   = fsa_btn_t'(~(s2_reg ^ s3_reg) & s3_reg & ~lvl_reg);
  assign combo   = (press.menu && (lvl_reg.enter || press.enter))
                 || (press.enter && lvl_reg.menu);
  assign menu_p  = press.menu && !combo;
  assign enter_p = press.enter && !combo;

  // bus slave: one wait cycle on every access, so reads come from a flop
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
  assign wr                  = avs_write_in && ack_reg;
  assign avs_readdata_out    = rdata_reg;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
      if (avs_read_in && !ack_reg)
        rdata_reg <= rmux;
    end
  end

  always_comb
  begin
    case (avs_address_in)
      OFF_CTRL:   rmux = {30'h0, ctrl_reg};
      OFF_SP1:    rmux = sp_reg[0];
      OFF_SP2:    rmux = sp_reg[1];
      OFF_TRIP:   rmux = {30'h0, trip_reg};
      OFF_LOCK:   rmux = {rlock_reg, plock_reg};
      OFF_STAT:   rmux = {19'h0, state_reg, 6'h0, conduct};
      OFF_IRQ_ST: rmux = {28'h0, irq_st_reg};
      OFF_IRQ_EN: rmux = {28'h0, irq_en_reg};
      OFF_GAS:    rmux = {temp_reg, pres_reg};
      default:    rmux = 32'h0000_0000;
    endcase
  end

  assign wval = be_merge(rmux, avs_writedata_in, avs_byteenable_in);

  // settings: the panel stores on enter, the bus writes last and wins a tie
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_reg  <= CTRL_RST;
      trip_reg  <= TRIP_RST;
      sp_reg[0] <= SP_RST;
      sp_reg[1] <= SP_RST;
      plock_reg <= LOCK_RST;
      rlock_reg <= LOCK_RST;
      pres_reg  <= 16'h0000;
      temp_reg  <= 16'h0000;
    end
    else
    begin
      if (enter_p)
      begin
        case (state_reg)
          MS_FLUID: ctrl_reg[CTRL_GAS] <= edit_reg[0];
          MS_PRES:  pres_reg           <= edit_reg;
          MS_TEMP:  temp_reg           <= edit_reg;
          MS_SP1T:  sp_reg[0].thr      <= edit_reg;
          MS_SP1H:  sp_reg[0].hys      <= edit_reg;
          MS_SP1D:  trip_reg[0]        <= edit_reg[0];
          MS_SP2T:  sp_reg[1].thr      <= edit_reg;
          MS_SP2H:  sp_reg[1].hys      <= edit_reg;
          MS_SP2D:  trip_reg[1]        <= edit_reg[0];
          MS_PLOCK: plock_reg          <= edit_reg;
          MS_RLOCK: rlock_reg          <= edit_reg;
          default:  ;
        endcase
      end
      if (wr)
      begin
        case (avs_address_in)
          OFF_CTRL: ctrl_reg  <= wval[1:0];
          OFF_SP1:  sp_reg[0] <= wval;
          OFF_SP2:  sp_reg[1] <= wval;
          OFF_TRIP: trip_reg  <= wval[1:0];
          OFF_LOCK: {rlock_reg, plock_reg} <= wval;
          OFF_GAS:  {temp_reg, pres_reg}   <= wval;
          default:  ;
        endcase
      end
    end
  end

  assign gated     = (plock_reg != LOCK_RST) && (rlock_reg != LOCK_RST);
  assign match     = edit_reg == ((state_reg == MS_CODE) ? plock_reg : rlock_reg);
  assign prog      = (state_reg >= MS_FLUID) || (state_reg == MS_RCODE && ret_reg);
  assign toggle_st = state_reg inside {MS_FLUID, MS_SP1D, MS_SP2D, MS_CLRGT};
  assign num_st    = state_reg inside {MS_CODE, MS_RCODE, MS_PRES, MS_TEMP, MS_SP1T,
                                       MS_SP1H, MS_SP2T, MS_SP2H, MS_PLOCK, MS_RLOCK};
  assign cnt_done  = cnt_reg == 32'(MSG_LEN - 1);

  always_comb
  begin
    state_next = state_reg;
    if (prog && menu_p)
      state_next = MS_SAVE;
    else
    begin
      case (state_reg)
        MS_RUN:
        begin
          if (combo && gated)
            state_next = MS_RCODE;
          else if (menu_p)
            state_next = (plock_reg != LOCK_RST) ? MS_CODE : MS_FLUID;
        end
        MS_CODE:  if (enter_p) state_next = match ? MS_FLUID : MS_RUN;
        MS_RCODE: if (enter_p) state_next = ret_reg ? MS_PLOCK : MS_RUN;
        MS_FLUID:
          if (enter_p)
            state_next = ctrl_reg[CTRL_GAS] ? MS_PRES
                       : (ctrl_reg[CTRL_EXT] ? MS_DAMP : MS_PULSE);
        MS_PRES:  if (enter_p) state_next = MS_TEMP;
        MS_TEMP:
          if (enter_p)
            state_next = ctrl_reg[CTRL_EXT] ? MS_DAMP : MS_PULSE;
        MS_PULSE: if (enter_p) state_next = MS_SP1T;
        MS_DAMP:  if (enter_p) state_next = MS_SP1T;
        MS_SP1T:  if (enter_p) state_next = MS_SP1H;
        MS_SP1H:  if (enter_p) state_next = MS_SP1D;
        MS_SP1D:  if (enter_p) state_next = MS_SP2T;
        MS_SP2T:  if (enter_p) state_next = MS_SP2H;
        MS_SP2H:  if (enter_p) state_next = MS_SP2D;
        MS_SP2D:  if (enter_p) state_next = MS_CLRGT;
        MS_CLRGT:
          if (enter_p)
            state_next = (edit_reg[0] && gated) ? MS_RCODE : MS_PLOCK;
        MS_PLOCK: if (enter_p) state_next = MS_RLOCK;
        MS_RLOCK: if (enter_p) state_next = MS_FLUID;
        MS_SAVE:  if (cnt_done) state_next = MS_BLANK;
        MS_BLANK: if (cnt_done) state_next = MS_VER;
        MS_VER:   if (cnt_done) state_next = MS_RUN;
        default:  state_next = MS_RUN;
      endcase
    end
  end

  always_comb
  begin
    case (state_next)
      MS_PRES:  load_val = pres_reg;
      MS_TEMP:  load_val = temp_reg;
      MS_FLUID: load_val = {15'h0, ctrl_reg[CTRL_GAS]};
      MS_SP1T:  load_val = sp_reg[0].thr;
      MS_SP1H:  load_val = sp_reg[0].hys;
      MS_SP1D:  load_val = {15'h0, trip_reg[0]};
      MS_SP2T:  load_val = sp_reg[1].thr;
      MS_SP2H:  load_val = sp_reg[1].hys;
      MS_SP2D:  load_val = {15'h0, trip_reg[1]};
      MS_PLOCK: load_val = plock_reg;
      MS_RLOCK: load_val = rlock_reg;
      MS_VER:   load_val = FW_VERSION;
      default:  load_val = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= MS_RUN;
      ret_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == MS_CLRGT)
        ret_reg <= 1'b1;
      else if (state_reg == MS_RUN)
        ret_reg <= 1'b0;
    end
  end

  assign nib = edit_reg[{dig_reg, 2'b00} +: 4];

  // most significant digit first; it is the one that flashes on entry
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      edit_reg <= 16'h0000;
      dig_reg  <= 2'h3;
    end
    else if (state_next != state_reg)
    begin
      edit_reg <= load_val;
      dig_reg  <= 2'h3;
    end
    else if (toggle_st && (press.up || press.right))
      edit_reg[0] <= ~edit_reg[0];
    else if (num_st && press.up)
      edit_reg[{dig_reg, 2'b00} +: 4] <= (nib >= DIG_MAX) ? 4'h0 : nib + 4'h1;
    else if (num_st && press.right)
      dig_reg <= dig_reg - 2'h1;
  end

  // message timer only runs in the three exit screens
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_reg <= 32'h0000_0000;
    else if (state_next != state_reg || !(state_reg inside {MS_SAVE, MS_BLANK, MS_VER}))
      cnt_reg <= 32'h0000_0000;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end

  assign clr_ev = press.hwrst
               || (state_reg == MS_RUN && combo && !gated)
               || (state_reg == MS_CLRGT && enter_p && edit_reg[0] && !gated)
               || (state_reg == MS_RCODE && enter_p && match);
  assign rej_ev = enter_p && (state_reg inside {MS_CODE, MS_RCODE}) && !match;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      clr_reg <= 1'b0;
    else
      clr_reg <= clr_ev;
  end

  genvar ch;
  generate
    for (ch = 0; ch < CH_N; ch++)
    begin : g_ch
      fsa_cmp u_cmp (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .flow_valid_in (flow_valid_in),
        .flow_in       (flow_rate_in),
        .setpt_in      (sp_reg[ch]),
        .trip_high_in  (trip_reg[ch]),
        .conduct_out   (conduct[ch]),
        .change_out    (change[ch])
      );
    end
  endgenerate

  // sticky events; a new event beats a clear in the same cycle
  assign irq_clr = (wr && avs_address_in == OFF_IRQ_CLR) ? wval[IRQ_N-1:0] : '0;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_st_reg <= '0;
      irq_en_reg <= '0;
      irq_reg    <= 1'b0;
    end
    else
    begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | {rej_ev, clr_reg, change};
      if (wr && avs_address_in == OFF_IRQ_EN)
        irq_en_reg <= wval[IRQ_N-1:0];
      irq_reg <= |(irq_st_reg & irq_en_reg);
    end
  end

  assign setpoint_oe_out  = conduct;
  assign setpoint_dat_out = 2'h0;
  assign total_clear_out  = clr_reg;
  assign menu_state_out   = state_reg;
  assign edit_value_out   = edit_reg;
  assign flash_digit_out  = dig_reg;
  assign irq_out          = irq_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  clr_default_a: assert property (state_reg != MS_CLRGT && state_next == MS_CLRGT
    |=> edit_reg == 16'h0000) else $error("clear prompt not at no");
  clr_yes_a: assert property (state_reg == MS_CLRGT && enter_p && edit_reg[0] && !gated
    |=> clr_reg && state_reg == MS_PLOCK) else $error("yes did not clear total");
  hw_clear_a: assert property (press.hwrst |=> total_clear_out)
    else $error("hardware reset missed");
  open_menu_a: assert property (state_reg == MS_RUN && menu_p && !combo
    && plock_reg == 16'h0000 |=> state_reg == MS_FLUID) else $error("open menu refused");
  lock_menu_a: assert property (state_reg == MS_CODE && enter_p && !menu_p
    |=> state_reg == ($past(match) ? MS_FLUID : MS_RUN)) else $error("lock code misjudged");
  reset_gate_a: assert property (state_reg == MS_RUN && combo && gated
    |=> state_reg == MS_RCODE && !clr_reg) else $error("gated clear slipped");
  free_reset_a: assert property (state_reg == MS_RUN && combo && rlock_reg == 16'h0000
    |=> clr_reg) else $error("free total reset refused");
  digit_up_a: assert property (num_st && press.up && state_next == state_reg
    |=> edit_reg != $past(edit_reg) && $stable(dig_reg)) else $error("digit not stepped");
  menu_order_a: assert property (state_reg == MS_SP2D && enter_p
    && !menu_p |=> state_reg == MS_CLRGT)
    else $error("menu order broken");
  gas_order_a: assert property (state_reg == MS_PRES && enter_p && !menu_p
    |=> state_reg == MS_TEMP) else $error("pressure not followed by temperature");
  exit_seq_a: assert property (state_reg == MS_BLANK && $past(state_reg) != MS_BLANK
    |-> $past(state_reg) == MS_SAVE) else $error("blank screen out of order");
  sp_write_a: assert property (wr && avs_address_in == OFF_SP1
    && avs_byteenable_in == 4'hF |=> sp_reg[0] == $past(avs_writedata_in))
    else $error("threshold write refused");

  unlock_cov_c: cover property (state_reg == MS_CODE ##1 state_reg == MS_FLUID);
  clear_cov_c: cover property (state_reg == MS_CLRGT ##1 clr_reg);
  exit_cov_c: cover property (state_reg == MS_VER ##1 state_reg == MS_RUN);
endmodule : fsa_top

// ---- sim/fsa_alarm_model.sv ----
`timescale 1ns/1ps
module fsa_alarm_model (
  input  wire logic [1:0] oe_in,
  input  wire logic [1:0] dat_in,
  output logic      [1:0] pin_out
);
  // pull-ups: a released collector reads high, never the last driven level
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pin_out[i] = oe_in[i] ? dat_in[i] : 1'b1;
    end
  end
endmodule : fsa_alarm_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  import fsa_pkg::*;
  logic clk, rst_b, rd, wr, wq, fv;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [15:0] fr, ev;
  logic [1:0] oe, od, pin, fd;
  logic tc, irq;
  fsa_btn_t btn;
  fsa_menu_t ms;
  int bad_count, n_checks, cyc, clr_n;
  fsa_top #(.MSG_LEN(16), .FW_VERSION(16'h0A5C)) u_dut (.core_clk_in(clk), .rst_b_in(rst_b),
    .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .btn_in(btn), .flow_valid_in(fv),
    .flow_rate_in(fr), .setpoint_oe_out(oe), .setpoint_dat_out(od), .total_clear_out(tc),
    .menu_state_out(ms), .edit_value_out(ev), .flash_digit_out(fd), .irq_out(irq));
  fsa_alarm_model u_alarm (.oe_in(oe), .dat_in(od), .pin_out(pin));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (tc === 1'b1) clr_n++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // waitrequest and read data are taken at the same rising edge; only then is the request dropped
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do
      @(posedge clk);
    while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic press(input logic [4:0] b);
    @(posedge clk);
    btn <= b;
    repeat (6) @(posedge clk);
    btn <= 5'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : press
  task automatic flow(input logic [15:0] v, input logic [1:0] exp);
    @(posedge clk);
    fv <= 1'b1;
    fr <= v;
    @(posedge clk);
    fv <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pin, exp);
  endtask : flow
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    fsa_menu_t w[9] = '{MS_PULSE, MS_SP1T, MS_SP1H, MS_SP1D, MS_SP2T, MS_SP2H, MS_SP2D,
                        MS_CLRGT, MS_PLOCK};
    {rst_b, rd, wr, fv, adr, wd, fr, btn} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, OFF_TRIP, 0);
    chk(q, 32'h3);
    bus(0, 6'h3C, 0);
    chk(q, 32'h0);
    $display("test reset values done");
    // large hysteresis on ch2 is taken as is, no range refusal
    bus(1, OFF_SP1, 32'h0002_0010);
    bus(1, OFF_SP2, 32'h0003_0020);
    bus(1, OFF_TRIP, 32'h1);
    bus(1, OFF_IRQ_EN, 32'h1);
    flow(16'd5, 2'b00);
    chk(irq, 1'b1);
    bus(0, OFF_IRQ_ST, 0);
    chk(q[0], 1'b1);
    bus(1, OFF_IRQ_CLR, 32'h1);
    repeat (2) @(negedge clk);
    chk(irq, 1'b0);
    flow(16'd8, 2'b00);
    flow(16'd10, 2'b01);
    flow(16'd8, 2'b01);
    flow(16'd7, 2'b00);
    flow(16'd20, 2'b01);
    flow(16'd23, 2'b01);
    flow(16'd24, 2'b11);
    bus(1, OFF_IRQ_EN, 32'h0);
    flow(16'd7, 2'b00);
    chk(irq, 1'b0);
    $display("test comparators done");
    press(5'h01);
    chk(clr_n, 1);
    press(5'h18);
    chk(clr_n, 2);
    press(5'h10);
    chk(ms, MS_FLUID);
    for (int i = 0; i < 9; i++)
    begin
      press(5'h08);
      chk(ms, w[i]);
      if (w[i] == MS_SP1T)
      begin
        chk(fd, 2'h3);
        press(5'h04);
        chk(ev, 16'h1010);
        press(5'h02);
        chk(fd, 2'h2);
      end
      if (w[i] == MS_PLOCK) chk(clr_n, 3);
      if (w[i] == MS_CLRGT) press(5'h04);
    end
    press(5'h08);
    chk(ms, MS_RLOCK);
    press(5'h08);
    chk(ms, MS_FLUID);
    press(5'h10);
    chk(ms, MS_SAVE);
    repeat (16) @(negedge clk);
    chk(ms, MS_BLANK);
    chk(ev, 16'h0000);
    repeat (16) @(negedge clk);
    chk(ms, MS_VER);
    chk(ev, 16'h0A5C);
    repeat (16) @(negedge clk);
    chk(ms, MS_RUN);
    bus(0, OFF_SP1, 0);
    chk(q[15:0], 16'h1010);
    $display("test menu done");
    bus(1, OFF_CTRL, 32'h3);
    for (int m = 0; m < 2; m++)
    begin
      press(5'h10);
      press(5'h08);
      chk(ms, MS_PRES);
      press(5'h04);
      press(5'h08);
      chk(ms, MS_TEMP);
      press(5'h08);
      chk(ms, m ? MS_PULSE : MS_DAMP);
      press(5'h10);
      repeat (50) @(negedge clk);
      bus(1, OFF_CTRL, 32'h1);
    end
    bus(0, OFF_GAS, 0);
    chk(q, 32'h0000_2000);
    $display("test gas done");
    bus(1, OFF_LOCK, 32'h0000_0001);
    press(5'h18);
    chk(clr_n, 4);
    press(5'h10);
    chk(ms, MS_CODE);
    press(5'h08);
    chk(ms, MS_RUN);
    bus(1, OFF_LOCK, 32'h0002_0001);
    press(5'h18);
    chk(ms, MS_RCODE);
    chk(clr_n, 4);
    bus(0, OFF_IRQ_ST, 0);
    chk(q, 32'h0000_000F);
    $display("test locks done");
    test_done();
  end
endmodule : tb
